// ### shared/lrc_consts.svh
`ifndef LRC_CONSTS_SVH
`define LRC_CONSTS_SVH

// register byte offsets
`define LRC_OFS_CTRL    4'h0
`define LRC_OFS_HCFG    4'h4
`define LRC_OFS_INIT    4'h8
`define LRC_OFS_STATUS  4'hc

// field positions
`define LRC_CTRL_MODE_LSB  0
`define LRC_CTRL_LOAD_BIT  8
`define LRC_HCFG_SEL_W     3
`define LRC_HCFG_TAB_LSB   16
`define LRC_INIT_G_LSB     16
`define LRC_STAT_RAM_BIT   8

// reset values
`define LRC_RST_MODE    2'h0
`define LRC_RST_HSEL    9'h000
`define LRC_RST_HTAB    8'h00
`define LRC_RST_INIT_F  16'h0000
`define LRC_RST_INIT_G  16'h0000

// lookup geometry
`define LRC_DEPTH       16
`define LRC_AW          4

`endif

// ### shared/lrc_pkg.sv
`default_nettype none
package lrc_pkg;
    // four exclusive uses of the lookup pair, one-hot
    typedef enum logic [3:0] {
        MODE_LOGIC = 4'b0001,
        MODE_LEVEL = 4'b0010,
        MODE_EDGE  = 4'b0100,
        MODE_DUAL  = 4'b1000
    } lrc_mode_t;

    // main cell state
    typedef struct packed {
        lrc_mode_t        mode;
        logic [2:0][2:0]  hsel;
        logic [7:0]       htab;
        logic [15:0]      init_f;
        logic [15:0]      init_g;
        logic             ack;
        logic [31:0]      dat;
        logic             ld;
    } lrc_cell_t;

    // storage array, one 2-bit word per address
    typedef struct packed {
        logic [15:0][1:0] arr;
    } lrc_store_t;
endpackage : lrc_pkg
`default_nettype wire

// ### shared/lrc_mem_if.sv
`default_nettype none
interface lrc_mem_if;
    logic        wen;       // write this cycle
    logic [1:0]  wmask;     // planes written
    logic [3:0]  waddr;     // write address
    logic [1:0]  wdata;     // write data
    logic        ld;        // preload both planes
    logic [15:0] ld_f;      // preload image, plane 0
    logic [15:0] ld_g;      // preload image, plane 1
    logic [3:0]  raddr_a;   // read port a address
    logic [3:0]  raddr_b;   // read port b address
    logic [1:0]  rdata_a;   // read port a word
    logic [1:0]  rdata_b;   // read port b word
    modport ctl (output wen, wmask, waddr, wdata, ld, ld_f, ld_g, raddr_a, raddr_b,
                 input rdata_a, rdata_b);
    modport mem (input wen, wmask, waddr, wdata, ld, ld_f, ld_g, raddr_a, raddr_b,
                 output rdata_a, rdata_b);
endinterface : lrc_mem_if
`default_nettype wire

// ### src/lrc_mem.sv
`include "lrc_consts.svh"
`default_nettype none
module lrc_mem #(
    parameter logic [15:0] F_INIT = `LRC_RST_INIT_F,
    parameter logic [15:0] G_INIT = `LRC_RST_INIT_G
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // storage port
    lrc_mem_if.mem   m
);
    lrc_pkg::lrc_store_t st_ff;    // registered array
    lrc_pkg::lrc_store_t nxt_st;   // next array

    // next array: preload beats a user write
    always_comb
    begin
        nxt_st = st_ff;
        for (int i = 0; i < `LRC_DEPTH; i++)
        begin
            if (m.ld)
            begin
                nxt_st.arr[i] = {m.ld_g[i], m.ld_f[i]};
            end
            else if (m.wen && (m.waddr == i[3:0]))
            begin
                // only masked planes change
                nxt_st.arr[i] = (st_ff.arr[i] & ~m.wmask) | (m.wdata & m.wmask);
            end
        end
    end

    // array register, preloaded image at reset
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            for (int i = 0; i < `LRC_DEPTH; i++)
            begin
                st_ff.arr[i] <= {G_INIT[i], F_INIT[i]};
            end
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // reads are combinational, no clock in the path
    assign m.rdata_a = st_ff.arr[m.raddr_a];
    assign m.rdata_b = st_ff.arr[m.raddr_b];

    // writes land only at the edge, never earlier
    property p_mem_commit;
        @(posedge CLK) disable iff (RESET)
        (m.wen && !m.ld && m.wmask == 2'h3) ##1 (m.raddr_a == $past(m.waddr))
        |-> m.rdata_a == $past(m.wdata);
    endproperty
    a_mem_commit: assert property (p_mem_commit)
        else $error("written word not stored at edge");
endmodule : lrc_mem
`default_nettype wire

// ### src/lrc_top.sv
// Behaviour
// - edge mode writes only on clock edge
// - reads follow address, no clock needed
// - dual mode: 16x1, read and write together
// - pair is exactly one of four uses
// - contents preloaded before any write
// - third lookup fed by F, G, controls
`include "lrc_consts.svh"
`default_nettype none
module lrc_top #(
    parameter logic [15:0] F_INIT = `LRC_RST_INIT_F,
    parameter logic [15:0] G_INIT = `LRC_RST_INIT_G
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [3:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // fabric side, same clock
    input  wire logic [3:0]  F_ADDR,
    input  wire logic [3:0]  G_ADDR,
    input  wire logic [1:0]  DIN,
    input  wire logic        RAM_WE,
    input  wire logic [3:0]  CTRL_IN,
    // lookup outputs
    output logic             F_OUT,
    output logic             G_OUT,
    output logic             H_OUT
);
    lrc_pkg::lrc_cell_t st_ff;      // registered state
    lrc_pkg::lrc_cell_t nxt_st;     // next state
    lrc_mem_if          mif ();     // storage link
    logic               bus_wr;     // write commits this edge
    logic [31:0]        rd_word;    // read mux
    logic [7:0]         hsrc;       // sources for the third lookup
    logic [2:0]         hidx;       // third lookup index

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // 2-bit field to one-hot mode; every code is a legal use
    function automatic lrc_pkg::lrc_mode_t mode_dec(input logic [1:0] c);
        case (c)
            2'h0:    return lrc_pkg::MODE_LOGIC;
            2'h1:    return lrc_pkg::MODE_LEVEL;
            2'h2:    return lrc_pkg::MODE_EDGE;
            2'h3:    return lrc_pkg::MODE_DUAL;
            default: return lrc_pkg::MODE_LOGIC;
        endcase
    endfunction : mode_dec

    // one-hot mode back to its field code
    function automatic logic [1:0] mode_enc(input lrc_pkg::lrc_mode_t md);
        case (md)
            lrc_pkg::MODE_LOGIC: return 2'h0;
            lrc_pkg::MODE_LEVEL: return 2'h1;
            lrc_pkg::MODE_EDGE:  return 2'h2;
            lrc_pkg::MODE_DUAL:  return 2'h3;
            default:             return 2'h0;
        endcase
    endfunction : mode_enc

    // write lands on the edge that the master samples ack
    assign bus_wr = CYC_I && STB_I && WE_I && st_ff.ack;

    // register read mux, unmapped reads as zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (ADR_I)
            `LRC_OFS_CTRL:
            begin
                rd_word[`LRC_CTRL_MODE_LSB +: 2] = mode_enc(st_ff.mode);
            end
            `LRC_OFS_HCFG:
            begin
                rd_word[8:0] = st_ff.hsel;
                rd_word[`LRC_HCFG_TAB_LSB +: 8] = st_ff.htab;
            end
            `LRC_OFS_INIT:
            begin
                rd_word = {st_ff.init_g, st_ff.init_f};
            end
            `LRC_OFS_STATUS:
            begin
                // live lookup outputs and ram flag
                rd_word[2:0] = {H_OUT, G_OUT, F_OUT};
                rd_word[`LRC_STAT_RAM_BIT] = (st_ff.mode != lrc_pkg::MODE_LOGIC);
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // next state: bus slave and configuration registers
    always_comb
    begin
        logic [31:0] w;
        w = 32'h0000_0000;
        nxt_st = st_ff;
        // single-cycle answer, dropped the cycle after
        nxt_st.ack = CYC_I && STB_I && !st_ff.ack;
        nxt_st.dat = (CYC_I && STB_I && !st_ff.ack) ? rd_word : st_ff.dat;
        nxt_st.ld = 1'b0;
        if (bus_wr)
        begin
            case (ADR_I)
                `LRC_OFS_CTRL:
                begin
                    w = lane_merge({22'h0, 1'b0, 7'h0, mode_enc(st_ff.mode)}, DAT_I, SEL_I);
                    nxt_st.mode = mode_dec(w[`LRC_CTRL_MODE_LSB +: 2]);
                    // self-clearing: copies the image into the array
                    nxt_st.ld = w[`LRC_CTRL_LOAD_BIT] && SEL_I[1];
                end
                `LRC_OFS_HCFG:
                begin
                    w = lane_merge({8'h0, st_ff.htab, 7'h0, st_ff.hsel}, DAT_I, SEL_I);
                    nxt_st.hsel = w[8:0];
                    nxt_st.htab = w[`LRC_HCFG_TAB_LSB +: 8];
                end
                `LRC_OFS_INIT:
                begin
                    w = lane_merge({st_ff.init_g, st_ff.init_f}, DAT_I, SEL_I);
                    nxt_st.init_f = w[15:0];
                    nxt_st.init_g = w[`LRC_INIT_G_LSB +: 16];
                end
                default:
                begin
                    // status and unmapped: write ignored, still acked
                    nxt_st.ld = 1'b0;
                end
            endcase
        end
    end

    // single state register
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            st_ff.mode   <= lrc_pkg::MODE_LOGIC;
            st_ff.hsel   <= `LRC_RST_HSEL;
            st_ff.htab   <= `LRC_RST_HTAB;
            st_ff.init_f <= F_INIT;
            st_ff.init_g <= G_INIT;
            st_ff.ack    <= 1'b0;
            st_ff.dat    <= 32'h0000_0000;
            st_ff.ld     <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // storage control; logic mode never writes, only the image loads
    always_comb
    begin
        mif.wen     = RAM_WE && (st_ff.mode != lrc_pkg::MODE_LOGIC);
        mif.wmask   = (st_ff.mode == lrc_pkg::MODE_DUAL) ? 2'h1 : 2'h3;
        mif.waddr   = F_ADDR;
        mif.wdata   = DIN;
        mif.ld      = st_ff.ld;
        mif.ld_f    = st_ff.init_f;
        mif.ld_g    = st_ff.init_g;
        mif.raddr_a = F_ADDR;
        mif.raddr_b = G_ADDR;
    end

    // array with reset preload
    lrc_mem #(
        .F_INIT (F_INIT),
        .G_INIT (G_INIT)
    ) u_mem (
        .CLK   (CLK),
        .RESET (RESET),
        .m     (mif)
    );

    // read paths, combinational from address
    always_comb
    begin
        case (st_ff.mode)
            lrc_pkg::MODE_LOGIC:
            begin
                F_OUT = mif.rdata_a[0];
                G_OUT = mif.rdata_b[1];
            end
            lrc_pkg::MODE_LEVEL:
            begin
                // latch-like: data passes through while enable is high
                F_OUT = RAM_WE ? DIN[0] : mif.rdata_a[0];
                G_OUT = RAM_WE ? DIN[1] : mif.rdata_a[1];
            end
            lrc_pkg::MODE_EDGE:
            begin
                // old word shows until the edge
                F_OUT = mif.rdata_a[0];
                G_OUT = mif.rdata_a[1];
            end
            lrc_pkg::MODE_DUAL:
            begin
                // port a writes and reads, port b reads freely
                F_OUT = mif.rdata_a[0];
                G_OUT = mif.rdata_b[0];
            end
            default:
            begin
                F_OUT = 1'b0;
                G_OUT = 1'b0;
            end
        endcase
    end

    // third lookup: each input picks F, G, a control line or zero
    assign hsrc = {2'b00, CTRL_IN, G_OUT, F_OUT};
    assign hidx = {hsrc[st_ff.hsel[2]], hsrc[st_ff.hsel[1]], hsrc[st_ff.hsel[0]]};
    assign H_OUT = st_ff.htab[hidx];

    // bus outputs from flip-flops
    assign ACK_O = st_ff.ack;
    assign DAT_O = st_ff.dat;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // no change without an edge-time enable; user holds inputs stable
    property p_edge_hold;
        (st_ff.mode == lrc_pkg::MODE_EDGE && !RAM_WE && !st_ff.ld)
        ##1 ($stable(F_ADDR) && st_ff.mode == lrc_pkg::MODE_EDGE)
        |-> $stable(F_OUT);
    endproperty
    a_edge_hold: assert property (p_edge_hold)
        else $error("edge ram output changed without a write");

    sequence s_edge_write;
        st_ff.mode == lrc_pkg::MODE_EDGE && RAM_WE && !st_ff.ld && !bus_wr;
    endsequence
    property p_edge_commit;
        s_edge_write ##1 ($stable(F_ADDR) && st_ff.mode == lrc_pkg::MODE_EDGE && !RAM_WE)
        |-> F_OUT == $past(DIN[0]) && G_OUT == $past(DIN[1]);
    endproperty
    a_edge_commit: assert property (p_edge_commit)
        else $error("edge write not visible after the edge");

    // image cannot change the cycle after a load: that cycle carries no ack
    property p_read_now;
        (st_ff.mode == lrc_pkg::MODE_EDGE && !RAM_WE && $past(st_ff.ld))
        |-> F_OUT == st_ff.init_f[F_ADDR];
    endproperty
    a_read_now: assert property (p_read_now)
        else $error("read did not follow address");

    sequence s_dual_write;
        st_ff.mode == lrc_pkg::MODE_DUAL && RAM_WE && !st_ff.ld && !bus_wr;
    endsequence
    property p_dual_read;
        s_dual_write ##1 (st_ff.mode == lrc_pkg::MODE_DUAL && G_ADDR == $past(F_ADDR)
                          && !(RAM_WE && F_ADDR == G_ADDR))
        |-> G_OUT == $past(DIN[0]);
    endproperty
    a_dual_read: assert property (p_dual_read)
        else $error("dual port read missed written bit");

    property p_one_use;
        $onehot(st_ff.mode);
    endproperty
    a_one_use: assert property (p_one_use)
        else $error("cell not in exactly one use");

    property p_preload;
        ($past(RESET) && st_ff.mode == lrc_pkg::MODE_LOGIC)
        |-> F_OUT == F_INIT[F_ADDR] && G_OUT == G_INIT[G_ADDR];
    endproperty
    a_preload: assert property (p_preload)
        else $error("preload image not present after reset");

    property p_h_from_f;
        (st_ff.hsel == 9'h000) |-> H_OUT == st_ff.htab[{3{F_OUT}}];
    endproperty
    a_h_from_f: assert property (p_h_from_f)
        else $error("third lookup not driven by F");

    property p_ack_once;
        ACK_O |=> !ACK_O;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held more than one cycle");
endmodule : lrc_top
`default_nettype wire

// ### bench/lrc_fabric.sv
`default_nettype none
// fabric user logic: lookup addresses, ram writes, control lines
module lrc_fabric (
    // lookup and ram port
    output var logic [3:0] f_addr,
    output var logic [3:0] g_addr,
    output var logic [1:0] din,
    output var logic       ram_we,
    // third lookup controls
    output var logic [3:0] ctrl_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle values from time zero
    initial
    begin
        f_addr = 4'h0;
        g_addr = 4'h0;
        din = 2'h0;
        ram_we = 1'b0;
        ctrl_in = 4'h0;
    end

    // called just after a rising edge and held until the next call,
    // so a write stays steady across the edge that stores it
    task automatic put(input logic [3:0] fa, ga, input logic [1:0] d, input logic we);
        f_addr  <= fa;
        g_addr  <= ga;
        ram_we  <= we;
        ctrl_in <= 4'($urandom);
        // a released data line must not keep showing its last value
        din     <= we ? d : ~din;
    endtask : put
endmodule : lrc_fabric
`default_nettype wire

// ### bench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [15:0] FI = 16'hc35a;  // preload image, plane f
    localparam logic [15:0] GI = 16'h96e1;  // preload image, plane g
    // readable bits per register; status is built apart
    localparam logic [31:0] MSK [4] = '{32'h3, 32'hff01ff, 32'hffffffff, 32'h0};

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    // bus master side
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic        ack, f_out, g_out, h_out;
    // fabric side
    logic [3:0]  f_addr, g_addr, ctrl_in;
    logic [1:0]  din;
    logic        ram_we;
    // reference model: register shadow and both planes
    logic [31:0] rm [4];
    logic [15:0] mf, mg;
    int          err_total, comparisons, cycles;

    always #10 clk = ~clk;

    lrc_top #(.F_INIT(FI), .G_INIT(GI)) i_dut (
        .CLK(clk), .RESET(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .F_ADDR(f_addr),
        .G_ADDR(g_addr), .DIN(din), .RAM_WE(ram_we), .CTRL_IN(ctrl_in),
        .F_OUT(f_out), .G_OUT(g_out), .H_OUT(h_out));

    lrc_fabric i_fab (.f_addr(f_addr), .g_addr(g_addr), .din(din), .ram_we(ram_we),
        .ctrl_in(ctrl_in));

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    // one comparison, counted
    task automatic check(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp)
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            err_total++;
    endtask : check

    // value the third lookup sees on one input
    function automatic logic src(input logic [2:0] s, input logic f, g);
        if (s == 3'h0)
            return f;
        if (s == 3'h1)
            return g;
        return (s < 3'h6) ? ctrl_in[s - 3'h2] : 1'b0;
    endfunction : src

    // expected {h, g, f}; level mode is transparent while writing
    function automatic logic [2:0] exp_out();
        logic [1:0] m;
        logic       f;
        logic       g;
        logic [2:0] x;
        m = rm[0][1:0];
        f = (m == 2'h1 && ram_we) ? din[0] : mf[f_addr];
        // single-port ram modes read both planes at the f address
        g = (m == 2'h1 && ram_we) ? din[1] : (m == 2'h3) ? mf[g_addr]
            : (m == 2'h0) ? mg[g_addr] : mg[f_addr];
        x = {src(rm[1][8:6], f, g), src(rm[1][5:3], f, g), src(rm[1][2:0], f, g)};
        return {rm[1][5'd16 + x], g, f};
    endfunction : exp_out

    task automatic chk();
        check({29'h0, h_out, g_out, f_out}, {29'h0, exp_out()});
    endtask : chk

    // classic single cycle; entered and left just after a rising edge
    task automatic wb(input logic w, input logic [3:0] a, s, input logic [31:0] d);
        logic [31:0] bm;
        logic [31:0] e;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        e = (a[3:2] == 2'h3) ? {23'h0, rm[0][1:0] != 2'h0, 5'h0, exp_out()} : rm[a[3:2]];
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        @(posedge clk);
        // bounded wait for the acknowledge
        repeat (20)
            if (ack !== 1'b1)
                @(posedge clk);
        check({31'h0, ack}, 32'h1);
        if (!w)
            check(dat_o, (a[1:0] != 2'h0) ? 32'h0 : e);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (w && a[1:0] == 2'h0 && a[3:2] != 2'h3)
            rm[a[3:2]] = ((rm[a[3:2]] & ~bm) | (d & bm)) & MSK[a[3:2]];
        // load copies the init image one edge after the write edge
        if (w && a == 4'h0 && s[1] && d[8])
            {mg, mf} = rm[2];
        @(posedge clk);
    endtask : wb

    // one fabric write, checked before and after its edge
    task automatic ram_step(input logic [3:0] a, b, input logic [1:0] d);
        logic [3:0] g;
        g = (rm[0][1:0] == 2'h3) ? b : a;
        i_fab.put(a, g, d, 1'b1);
        #1 chk();
        @(posedge clk);
        if (rm[0][1:0] != 2'h0)
            mf[a] = d[0];
        if (rm[0][1:0] == 2'h1 || rm[0][1:0] == 2'h2)
            mg[a] = d[1];
        i_fab.put(a, g, d, 1'b0);
        #1 chk();
        @(posedge clk);
    endtask : ram_step

    // address sweep: reads follow the address within the cycle
    task automatic sweep();
        for (int a = 0; a < 16; a++)
        begin
            i_fab.put(4'(a), 4'(a), 2'h0, 1'b0);
            #1 chk();
            @(posedge clk);
        end
    endtask : sweep

    // hang guard, far above the length of the run
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_total++;
            finish_test();
        end
    end

    initial
    begin
        void'($urandom(32'h17b1));
        rm = '{32'h0, 32'h0, {GI, FI}, 32'h0};
        {mg, mf} = {GI, FI};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // reset contents, then every address written and read back
        sweep();
        for (int a = 0; a < 16; a++)
            wb(1'b0, 4'(a), 4'hf, 32'h0);
        for (int a = 0; a < 16; a++)
            wb(1'b1, 4'(a), 4'($urandom), $urandom);
        for (int a = 0; a < 16; a++)
            wb(1'b0, 4'(a), 4'hf, 32'h0);
        sweep();
        // fresh image, then edge mode and load in one write
        wb(1'b1, 4'h8, 4'hf, $urandom);
        wb(1'b1, 4'h0, 4'hf, 32'h0000_0102);
        sweep();
        $display("test registers and preload done");
        // every use of the lookup pair
        for (int m = 0; m < 4; m++)
        begin
            wb(1'b1, 4'h0, 4'hf, 32'(m));
            repeat (8)
                ram_step(4'($urandom), 4'($urandom), 2'($urandom));
            // same address on both ports, so dual reads see the write
            ram_step(4'h5, 4'h5, 2'($urandom));
            sweep();
            wb(1'b0, 4'hc, 4'hf, 32'h0);
        end
        $display("test ram modes done");
        // third lookup with random sources and table
        repeat (12)
        begin
            wb(1'b1, 4'h4, 4'hf, $urandom);
            i_fab.put(4'($urandom), 4'($urandom), 2'h0, 1'b0);
            #1 chk();
            @(posedge clk);
            wb(1'b0, 4'hc, 4'hf, 32'h0);
        end
        $display("test third lookup done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
